// file: verilog/icts_pkg.sv
// Shared constants and types for the image counter and time stamp block.
// Assumes a single 200 MHz clock domain and a synchronous active-high reset.
package icts_pkg;

  localparam int SEQ_W      = 32;
  localparam int TIME_W     = 64;
  localparam int CLK_PS     = 5000;
  localparam int TICK_PS    = 8000;
  localparam int PHASE_W    = 16;
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(CLK_PS);
  localparam logic [PHASE_W-1:0] PHASE_WRAP = PHASE_W'(TICK_PS);
  localparam logic [SEQ_W-1:0]   SEQ_RST    = 32'h0000_0000;
  localparam logic [SEQ_W-1:0]   SEQ_MAX    = 32'hFFFF_FFFF;
  localparam logic [TIME_W-1:0]  TIME_RST   = 64'h0000_0000_0000_0000;

  // Values of the counter unit picker and of the counted event
  localparam logic [1:0] UNIT_FIRST    = 2'h0;
  localparam logic [1:0] UNIT_SECOND   = 2'h1;
  localparam logic [1:0] EVT_TRIGGER   = 2'h0;
  localparam logic [1:0] EVT_IMG_BEGIN = 2'h1;

  // Metadata kind selector values
  localparam logic [1:0] KIND_IMG_NUM  = 2'h0;
  localparam logic [1:0] KIND_CAP_TIME = 2'h1;

  typedef enum logic [1:0] {
    ICTS_CLR_OFF  = 2'h0,
    ICTS_CLR_IN1  = 2'h1,
    ICTS_CLR_IN2  = 2'h2,
    ICTS_CLR_SOFT = 2'h3
  } icts_clr_e;

endpackage

// file: verilog/icts_seq_if.sv
// Carrier between the control logic and the image sequence counter.
// Assumes both ends share ref_clk.
`timescale 1ns/10ps
`default_nettype none
interface icts_seq_if #(
  parameter int W = 32
);
  logic         count_evt;
  logic         clear_evt;
  logic [W-1:0] count;

  modport ctrl (output count_evt, output clear_evt, input count);
  modport cnt  (input count_evt, input clear_evt, output count);
endinterface
`default_nettype wire

// file: verilog/icts_seq_counter.sv
// Image sequence counter: counts image begin events, clears on request.
// Assumes event and clear strobes are one-cycle pulses on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module icts_seq_counter
  import icts_pkg::*;
#(
  parameter int W = SEQ_W
) (
  input  wire logic   ref_clk,
  input  wire logic   rst,
  input  wire logic   clk_en,
  icts_seq_if.cnt     seq
);
  // unsigned count, 32 bits by default
  logic [W-1:0] count_reg;

  assign seq.count = count_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_reg <= W'(SEQ_RST);
    end
    else if (clk_en)
    begin
      // a clear and an image together make that image number zero
      if (seq.clear_evt)
      begin
        count_reg <= seq.count_evt ? W'(1) : W'(SEQ_RST);
      end
      else if (seq.count_evt)
      begin
        count_reg <= count_reg + W'(1);
      end
    end
  end

  property p_seq_wrap;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && seq.count_evt && !seq.clear_evt && count_reg == W'(SEQ_MAX))
      |=> (count_reg == W'(0));
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("sequence counter did not wrap");

  c_seq_wrap: cover property (@(posedge ref_clk) disable iff (rst)
    clk_en && seq.count_evt && count_reg == W'(SEQ_MAX));
endmodule
`default_nettype wire

// file: verilog/icts_timebase.sv
// Free-running time base ticking every 8 ns, derived from the 5 ns clock
// by a phase accumulator, so the tick rate is exact on average.
// Assumes rst is the device reset.
`timescale 1ns/10ps
`default_nettype none
module icts_timebase
  import icts_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  output var  logic [TIME_W-1:0] time_now
);
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_sum;
  logic               tick;
  logic [TIME_W-1:0]  time_reg;
  logic               tick_q;

  assign phase_sum = phase_reg + PHASE_STEP;
  assign tick      = (phase_sum >= PHASE_WRAP);
  assign time_now  = time_reg;

  // one tick per 8 ns on average
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_reg <= '0;
    end
    else if (clk_en)
    begin
      phase_reg <= tick ? phase_sum - PHASE_WRAP : phase_sum;
    end
  end

  // wraps on overflow, untouched by sequence clears
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      time_reg <= TIME_RST;
    end
    else if (clk_en && tick)
    begin
      time_reg <= time_reg + TIME_W'(1);
    end
  end

  // five ticks per eight cycles, so an idle cycle never repeats
  property p_tick_rate;
    @(posedge ref_clk) disable iff (rst || !clk_en)
    !tick |=> tick;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("time base tick spacing wrong");

  // the count only ever steps by one tick
  property p_time_step;
    @(posedge ref_clk) disable iff (rst)
    clk_en |=> (time_reg == $past(time_reg) + TIME_W'(tick_q));
  endproperty
  always_ff @(posedge ref_clk)
  begin
    tick_q <= tick;
  end
  a_time_step: assert property (p_time_step) else $error("time base step wrong");
endmodule
`default_nettype wire

// file: verilog/icts_top.sv
// Image metadata block: image sequence counter with selectable clear,
// trigger arrival counter, time base and capture-time sampling, and the
// per-image metadata chunk outputs.
// Assumes trigger, image begin and clear command are one-cycle pulses from
// ref_clk logic; the two input lines are asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module icts_top
  import icts_pkg::*;
#(
  parameter int SEQ_WIDTH = SEQ_W
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic                 acq_trigger,
  input  wire logic                 image_begin_event,
  input  wire logic                 io_input_one,
  input  wire logic                 io_input_two,
  input  wire logic [1:0]           counter_unit_pick,
  input  wire logic [1:0]           count_event_origin,
  input  wire logic [1:0]           count_clear_origin,
  input  wire logic                 count_clear_origin_wr,
  input  wire logic                 count_clear_command,
  input  wire logic                 metadata_attach_mode,
  input  wire logic [1:0]           metadata_kind_select,
  input  wire logic                 metadata_kind_on,
  input  wire logic                 metadata_kind_wr,
  output var  logic [1:0]           clear_origin_now,
  output var  logic                 number_on_now,
  output var  logic                 time_on_now,
  output var  logic [SEQ_WIDTH-1:0] seq_count_now,
  output var  logic [SEQ_WIDTH-1:0] trigger_count_now,
  output var  logic                 chunk_valid,
  output var  logic                 image_number_en,
  output var  logic [SEQ_WIDTH-1:0] image_number_field,
  output var  logic                 capture_time_en,
  output var  logic [TIME_W-1:0]    capture_time_field
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  icts_seq_if #(.W(SEQ_WIDTH)) seq ();

  logic [TIME_W-1:0]    time_now;
  icts_clr_e            clr_origin_reg;
  logic                 num_on_reg;
  logic                 time_on_reg;
  logic [TIME_W-1:0]    capt_reg;
  logic [SEQ_WIDTH-1:0] trig_count_reg;
  logic [2:0]           in1_sync_reg;
  logic [2:0]           in2_sync_reg;
  logic                 in1_rise;
  logic                 in2_rise;
  logic                 clear_now;

  icts_seq_counter #(.W(SEQ_WIDTH)) u_seq (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .seq     (seq)
  );

  icts_timebase u_time (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .time_now (time_now)
  );

  // Two-stage synchronisers; the third stage only serves edge detection
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      in1_sync_reg <= 3'h0;
      in2_sync_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      in1_sync_reg <= {in1_sync_reg[1:0], io_input_one};
      in2_sync_reg <= {in2_sync_reg[1:0], io_input_two};
    end
  end

  assign in1_rise = in1_sync_reg[1] && !in1_sync_reg[2];
  assign in2_rise = in2_sync_reg[1] && !in2_sync_reg[2];

  // origin accepted only when the sequence unit is addressed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      clr_origin_reg <= ICTS_CLR_OFF;
    end
    else if (clk_en && count_clear_origin_wr && counter_unit_pick == UNIT_SECOND
             && count_event_origin == EVT_IMG_BEGIN)
    begin
      clr_origin_reg <= icts_clr_e'(count_clear_origin);
    end
  end

  always_comb
  begin
    if (clr_origin_reg == ICTS_CLR_IN1)
    begin
      clear_now = in1_rise;
    end
    else if (clr_origin_reg == ICTS_CLR_IN2)
    begin
      clear_now = in2_rise;
    end
    else if (clr_origin_reg == ICTS_CLR_SOFT)
    begin
      clear_now = count_clear_command;
    end
    else
    begin
      clear_now = 1'b0;
    end
  end

  // every image begin advances the count
  // frames later dropped by buffering were still counted
  assign seq.count_evt = image_begin_event;
  assign seq.clear_evt = clear_now;

  // attach mode gates the per-kind enables
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      num_on_reg  <= 1'b0;
      time_on_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!metadata_attach_mode)
      begin
        num_on_reg  <= 1'b0;
        time_on_reg <= 1'b0;
      end
      else if (metadata_kind_wr && metadata_kind_select == KIND_IMG_NUM)
      begin
        num_on_reg <= metadata_kind_on;
      end
      else if (metadata_kind_wr && metadata_kind_select == KIND_CAP_TIME)
      begin
        time_on_reg <= metadata_kind_on;
      end
    end
  end

  // sample the time base on the trigger
  // trigger counter reads one after the first trigger
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      capt_reg       <= TIME_RST;
      trig_count_reg <= '0;
    end
    else if (clk_en && acq_trigger)
    begin
      capt_reg       <= time_now;
      trig_count_reg <= trig_count_reg + SEQ_WIDTH'(1);
    end
  end

  // metadata chunk: image number and capture time
  // The stamped number is the count before this image's increment, or zero when a clear comes with the image
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chunk_valid        <= 1'b0;
      image_number_en    <= 1'b0;
      capture_time_en    <= 1'b0;
      image_number_field <= '0;
      capture_time_field <= TIME_RST;
    end
    else if (clk_en)
    begin
      chunk_valid     <= image_begin_event;
      image_number_en <= image_begin_event && num_on_reg && metadata_attach_mode;
      capture_time_en <= image_begin_event && time_on_reg && metadata_attach_mode;
      if (image_begin_event)
      begin
        image_number_field <= clear_now ? SEQ_WIDTH'(0) : seq.count;
        capture_time_field <= acq_trigger ? time_now : capt_reg;
      end
    end
  end

  // Status mirrors, registered so every output comes from a flop
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      clear_origin_now  <= 2'(ICTS_CLR_OFF);
      number_on_now     <= 1'b0;
      time_on_now       <= 1'b0;
      seq_count_now     <= '0;
      trigger_count_now <= '0;
    end
    else if (clk_en)
    begin
      clear_origin_now  <= 2'(clr_origin_reg);
      number_on_now     <= num_on_reg;
      time_on_now       <= time_on_reg;
      seq_count_now     <= seq.count;
      trigger_count_now <= trig_count_reg;
    end
  end

  property p_seq_step;
    clk_en && image_begin_event && !clear_now |=> seq.count == $past(seq.count) + SEQ_WIDTH'(1);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence count did not step");

  property p_mode_off;
    clk_en && !metadata_attach_mode |=> !num_on_reg && !time_on_reg;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("enable survived mode off");

  // number chunk carries the pre-increment count
  property p_num_chunk;
    clk_en && image_begin_event && num_on_reg && metadata_attach_mode && !clear_now
      |=> chunk_valid && image_number_en && image_number_field == $past(seq.count);
  endproperty
  a_num_chunk: assert property (p_num_chunk) else $error("image number chunk wrong");

  // unselected software command leaves the count alone
  property p_soft_ignored;
    clk_en && count_clear_command && clr_origin_reg != ICTS_CLR_SOFT && !image_begin_event
      && !in1_rise && !in2_rise |=> $stable(seq.count);
  endproperty
  a_soft_ignored: assert property (p_soft_ignored) else $error("stray clear acted");

  // selected software command clears within one cycle
  property p_soft_clear;
    clk_en && count_clear_command && clr_origin_reg == ICTS_CLR_SOFT && !image_begin_event
      |=> seq.count == SEQ_WIDTH'(0) ##1 seq_count_now == SEQ_WIDTH'(0);
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("software clear missed");

  // origin unchanged without an origin write
  property p_origin_hold;
    clk_en && !count_clear_origin_wr |=> $stable(clr_origin_reg);
  endproperty
  a_origin_hold: assert property (p_origin_hold) else $error("clear origin changed");

  property p_capture;
    clk_en && acq_trigger |=> capt_reg == $past(time_now);
  endproperty
  a_capture: assert property (p_capture) else $error("capture time not sampled");

  // time chunk matches the last capture
  property p_time_chunk;
    clk_en && image_begin_event && time_on_reg && metadata_attach_mode && !acq_trigger
      |=> capture_time_en && capture_time_field == $past(capt_reg);
  endproperty
  a_time_chunk: assert property (p_time_chunk) else $error("capture time chunk wrong");

  property p_trig_step;
    clk_en && acq_trigger |=> trig_count_reg == $past(trig_count_reg) + SEQ_WIDTH'(1);
  endproperty
  a_trig_step: assert property (p_trig_step) else $error("trigger count wrong");

  c_num_chunk:  cover property (image_number_en);
  c_time_chunk: cover property (capture_time_en);
  c_line_clear: cover property (clk_en && clear_now && clr_origin_reg == ICTS_CLR_IN1);
  c_soft_clear: cover property (clk_en && clear_now && clr_origin_reg == ICTS_CLR_SOFT);
endmodule
`default_nettype wire

// file: verification/icts_host_model.sv
// Host side receiving images with trailing metadata chunks.
// Assumes chunk strobes are one-cycle pulses sampled on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module icts_host_model
  import icts_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic chunk_valid,
  input  wire logic image_number_en,
  input  wire logic capture_time_en,
  output var  int   n_number,
  output var  int   n_time
);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      n_number <= 0;
      n_time   <= 0;
    end
    else if (chunk_valid === 1'b1)
    begin
      n_number <= n_number + int'(image_number_en === 1'b1);
      n_time   <= n_time + int'(capture_time_en === 1'b1);
    end
  end
endmodule
`default_nettype wire

// file: verification/test_icts_top.sv
// Self-checking bench for the image counter and time stamp block.
// Assumes a narrowed sequence width so the rollover is reachable quickly.
`timescale 1ns/10ps
`default_nettype none
module test_image_counter_timestamp_chunks;
  import icts_pkg::*;
  localparam int SW = 8;
  logic              ref_clk, rst, trig, ibe, in1, in2, owr, cmd, mode, kon, kwr;
  logic [1:0]        unit, evt, orig, ksel, orig_now;
  logic              num_on, time_on, cv, num_en, time_en;
  logic [SW-1:0]     seq_now, trig_now, num_f, cnt;
  logic [TIME_W-1:0] time_f, t0;
  int                n_mismatch, n_compared, n_on, n_number, n_time;

  icts_top #(.SEQ_WIDTH(SW)) dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .acq_trigger(trig), .image_begin_event(ibe), .io_input_one(in1), .io_input_two(in2),
    .counter_unit_pick(unit), .count_event_origin(evt), .count_clear_origin(orig),
    .count_clear_origin_wr(owr), .count_clear_command(cmd), .metadata_attach_mode(mode),
    .metadata_kind_select(ksel), .metadata_kind_on(kon), .metadata_kind_wr(kwr),
    .clear_origin_now(orig_now), .number_on_now(num_on), .time_on_now(time_on),
    .seq_count_now(seq_now), .trigger_count_now(trig_now), .chunk_valid(cv),
    .image_number_en(num_en), .image_number_field(num_f), .capture_time_en(time_en),
    .capture_time_field(time_f));
  icts_host_model host_u (.ref_clk(ref_clk), .rst(rst), .chunk_valid(cv),
    .image_number_en(num_en), .capture_time_en(time_en), .n_number(n_number),
    .n_time(n_time));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Raise one strobe for exactly one sampling edge, then look past that edge
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: trig <= 1'b1;
      1: ibe  <= 1'b1;
      2: owr  <= 1'b1;
      3: cmd  <= 1'b1;
      default: kwr <= 1'b1;
    endcase
    @(posedge ref_clk);
    {trig, ibe, owr, cmd, kwr} <= 5'h00;
    #1;
  endtask

  task automatic img(input logic en);
    pulse(1);
    cmp(cv, 1'b1);
    cmp(num_en, en);
    if (en)
      cmp(num_f, cnt);
    n_on += int'(en);
    cnt = cnt + 1'b1;
  endtask

  task automatic set_origin(input logic [1:0] u, input logic [1:0] e, input logic [1:0] o);
    @(posedge ref_clk);
    unit <= u;
    evt  <= e;
    orig <= o;
    pulse(2);
    step(1);
  endtask

  task automatic set_kind(input logic [1:0] s, input logic on);
    @(posedge ref_clk);
    ksel <= s;
    kon  <= on;
    pulse(4);
    step(1);
  endtask

  task automatic line_rise(input int which);
    @(posedge ref_clk);
    if (which == 1)
      in1 <= 1'b1;
    else
      in2 <= 1'b1;
    step(6);
    @(posedge ref_clk);
    in1 <= 1'b0;
    in2 <= 1'b0;
    step(4);
  endtask

  task automatic t_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    cnt = '0;
    n_on = 0;
    pulse(0);
    step(1);
    cmp(trig_now, 8'h01);
    cmp(seq_now, 8'h00);
    cmp(orig_now, ICTS_CLR_OFF);
    // Trigger right after release must see the restarted time base
    img(1'b0);
    cmp(time_f, 64'h0000_0000_0000_0000);
    $display("test reset done");
  endtask

  task automatic t_count();
    @(posedge ref_clk);
    mode <= 1'b1;
    set_kind(KIND_IMG_NUM, 1'b1);
    cmp(num_on, 1'b1);
    repeat (4) img(1'b1);
    step(1);
    cmp(seq_now, cnt);
    $display("test count done");
  endtask

  task automatic t_mode();
    @(posedge ref_clk);
    mode <= 1'b0;
    step(2);
    cmp(num_on, 1'b0);
    img(1'b0);
    set_kind(KIND_IMG_NUM, 1'b1);
    @(posedge ref_clk);
    mode <= 1'b1;
    step(2);
    cmp(num_on, 1'b0);
    img(1'b0);
    set_kind(KIND_IMG_NUM, 1'b1);
    $display("test mode done");
  endtask

  task automatic t_soft();
    pulse(3);
    step(2);
    cmp(seq_now, cnt);
    set_origin(UNIT_FIRST, EVT_IMG_BEGIN, ICTS_CLR_SOFT);
    cmp(orig_now, ICTS_CLR_OFF);
    set_origin(UNIT_SECOND, EVT_IMG_BEGIN, ICTS_CLR_SOFT);
    cmp(orig_now, ICTS_CLR_SOFT);
    pulse(3);
    step(2);
    cmp(seq_now, 8'h00);
    cnt = '0;
    img(1'b1);
    $display("test soft clear done");
  endtask

  task automatic t_time();
    set_kind(KIND_CAP_TIME, 1'b1);
    pulse(0);
    img(1'b1);
    t0 = time_f;
    // Triggers sixteen edges apart span exactly ten ticks from any phase
    pulse(3);
    step(10);
    pulse(0);
    cnt = '0;
    img(1'b1);
    cmp(time_f - t0, 64'h0000_0000_0000_000A);
    cmp(time_en, 1'b1);
    cmp(time_f, t0 + 64'h000A);
    cmp(time_on, 1'b1);
    $display("test time done");
  endtask

  task automatic t_lines();
    for (int l = 1; l <= 2; l++)
    begin
      set_origin(UNIT_SECOND, EVT_IMG_BEGIN, 2'(l));
      img(1'b1);
      line_rise(3 - l);
      cmp(seq_now, cnt);
      line_rise(l);
      cmp(seq_now, 8'h00);
      cnt = '0;
    end
    $display("test lines done");
  endtask

  task automatic t_wrap();
    repeat (300) img(1'b1);
    step(2);
    cmp(seq_now, cnt);
    cmp(n_number, n_on);
    cmp(n_time, 64'h0000_0000_0000_0130);
    $display("test wrap done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {rst, trig, ibe, in1, in2, owr, cmd, mode, kon, kwr} = 10'h200;
    {unit, evt, orig, ksel} = 8'h00;
    n_mismatch = 0;
    n_compared = 0;
    t_reset();
    t_count();
    t_mode();
    t_soft();
    t_time();
    t_lines();
    t_wrap();
    t_reset();
    final_report();
  end

  // Whole run is under eight hundred cycles; this leaves a wide margin
  initial
  begin
    #100000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire
